//--- src/pfrp_read_port.v
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "pfrp_regs.vh"
module pfrp_read_port #(
    parameter ADDR_WIDTH  = `PFRP_FLASH_ADDR_WIDTH,
    parameter WORD_WIDTH  = `PFRP_WORD_WIDTH,
    parameter LATENCY     = `PFRP_FLASH_LATENCY
) (
    input  wire                         clock,
    input  wire                         rst_n,
    input  wire [`PFRP_ADDR_WIDTH-1:0]  regAddr,
    input  wire [7:0]                   regWriteData,
    input  wire                         regWrite,
    input  wire                         regRead,
    output reg  [7:0]                   regReadData,
    output reg  [ADDR_WIDTH-1:0]        flashAddr,
    output reg                          flashReadEnable,
    input  wire [WORD_WIDTH-1:0]        flashReadData,
    output reg                          readBusy
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_WAIT  = 3'b010;
    localparam ST_DONE  = 3'b100;
    localparam CNT_W    = 4;
    localparam [CNT_W-1:0] LAT_LAST = LATENCY - 1;

    wire                 sysRst_n;
    reg  [2:0]           state;
    reg  [2:0]           next_state;
    reg  [CNT_W-1:0]     waitCount;
    reg                  trigger;
    reg                  reservedBit;
    reg  [7:0]           next_readData;
    wire [7:0]           addrLow;
    wire [`PFRP_ADDR_HIGH_WIDTH-1:0] addrHigh;
    wire [7:0]           wordLow;
    wire [`PFRP_WORD_HIGH_WIDTH-1:0] wordHigh;
    wire                 wrControl;
    wire                 wrAddrLow;
    wire                 wrAddrHigh;
    wire                 startRead;
    wire                 finishRead;

    // Reset released through two flops; assertion stays asynchronous
    pfrp_sync_bit #(
        .RESET_VALUE (1'b0)
    ) uRstSync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (1'b1),
        .dout  (sysRst_n)
    );

    // Write decodes
    assign wrControl  = regWrite && (regAddr == `PFRP_OFF_CONTROL);
    assign wrAddrLow  = regWrite && (regAddr == `PFRP_OFF_ADDR_LOW);
    assign wrAddrHigh = regWrite && (regAddr == `PFRP_OFF_ADDR_HIGH);
    // Only a one starts a read; a zero is dropped
    assign startRead  = wrControl
                        && regWriteData[`PFRP_TRIGGER_BIT]
                        && !trigger;
    assign finishRead = (state == ST_DONE);

    // Address low byte
    pfrp_byte_reg #(
        .WIDTH (8)
    ) uAddrLow (
        .clock (clock),
        .rst_n (sysRst_n),
        .load  (wrAddrLow && !trigger),
        .din   (regWriteData),
        .dout  (addrLow)
    );

    // Address high byte, only the implemented bits are stored
    pfrp_byte_reg #(
        .WIDTH (`PFRP_ADDR_HIGH_WIDTH)
    ) uAddrHigh (
        .clock (clock),
        .rst_n (sysRst_n),
        .load  (wrAddrHigh && !trigger),
        .din   (regWriteData[`PFRP_ADDR_HIGH_WIDTH-1:0]),
        .dout  (addrHigh)
    );

    // Data low byte, loaded by the fetch only
    pfrp_byte_reg #(
        .WIDTH (8)
    ) uWordLow (
        .clock (clock),
        .rst_n (sysRst_n),
        .load  (finishRead),
        .din   (flashReadData[7:0]),
        .dout  (wordLow)
    );

    // Data high byte, six implemented bits
    pfrp_byte_reg #(
        .WIDTH (`PFRP_WORD_HIGH_WIDTH)
    ) uWordHigh (
        .clock (clock),
        .rst_n (sysRst_n),
        .load  (finishRead),
        .din   (flashReadData[WORD_WIDTH-1:8]),
        .dout  (wordHigh)
    );

    // Read sequencer next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (startRead) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (waitCount == LAT_LAST) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer, latency counter and flash strobe
    always @(posedge clock or negedge sysRst_n) begin
        if (!sysRst_n) begin
            state           <= ST_IDLE;
            waitCount       <= {CNT_W{1'b0}};
            flashAddr       <= {ADDR_WIDTH{1'b0}};
            flashReadEnable <= 1'b0;
        end else begin
            state <= next_state;
            if (startRead) begin
                // Address captured once; later writes cannot tear it
                flashAddr <= {addrHigh, addrLow};
                waitCount <= {CNT_W{1'b0}};
            end else if (state == ST_WAIT) begin
                waitCount <= waitCount + 1'b1;
            end
            // One access per trigger, held across the latency
            flashReadEnable <= (next_state == ST_WAIT);
        end
    end

    // Trigger bit: set by software, cleared by hardware only
    always @(posedge clock or negedge sysRst_n) begin
        if (!sysRst_n) begin
            trigger     <= 1'b0;
            reservedBit <= `PFRP_RESERVED_RESET;
            readBusy    <= 1'b0;
        end else begin
            if (startRead) begin
                trigger <= 1'b1;
            end else if (finishRead) begin
                trigger <= 1'b0;
            end
            readBusy    <= (next_state != ST_IDLE);
            reservedBit <= `PFRP_RESERVED_RESET;
        end
    end

    // Read mux; unmapped addresses answer zero
    always @* begin
        next_readData = `PFRP_BYTE_RESET;
        case (regAddr)
            `PFRP_OFF_CONTROL: begin
                next_readData[`PFRP_RESERVED_BIT] = reservedBit;
                next_readData[`PFRP_TRIGGER_BIT]  = trigger;
            end
            `PFRP_OFF_WORD_LOW: begin
                next_readData = wordLow;
            end
            `PFRP_OFF_WORD_HIGH: begin
                next_readData[`PFRP_WORD_HIGH_WIDTH-1:0] = wordHigh;
            end
            `PFRP_OFF_ADDR_LOW: begin
                next_readData = addrLow;
            end
            `PFRP_OFF_ADDR_HIGH: begin
                next_readData[`PFRP_ADDR_HIGH_WIDTH-1:0] = addrHigh;
            end
            default: begin
                next_readData = `PFRP_BYTE_RESET;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clock or negedge sysRst_n) begin
        if (!sysRst_n) begin
            regReadData <= `PFRP_BYTE_RESET;
        end else if (regRead) begin
            regReadData <= next_readData;
        end else begin
            regReadData <= `PFRP_BYTE_RESET;
        end
    end
endmodule // pfrp_read_port

//--- src/pfrp_regs.vh
`ifndef PFRP_REGS_VH
`define PFRP_REGS_VH

// Register addresses on the special-function-register port
`define PFRP_ADDR_WIDTH        9
`define PFRP_OFF_CONTROL       9'h18C
`define PFRP_OFF_WORD_LOW      9'h18D
`define PFRP_OFF_ADDR_LOW      9'h18E
`define PFRP_OFF_WORD_HIGH     9'h18F
`define PFRP_OFF_ADDR_HIGH     9'h190

// Field positions and widths
`define PFRP_TRIGGER_BIT       0
`define PFRP_RESERVED_BIT      7
`define PFRP_WORD_WIDTH        14
`define PFRP_FLASH_ADDR_WIDTH  13
`define PFRP_WORD_HIGH_WIDTH   6
`define PFRP_ADDR_HIGH_WIDTH   5

// Reset values
`define PFRP_RESERVED_RESET    1'h1
`define PFRP_BYTE_RESET        8'h00

// Flash access latency in system clocks (sync array model)
`define PFRP_FLASH_LATENCY     2

`endif

//--- src/pfrp_sync_bit.v
`timescale 1ns/1ps
// Two-stage synchroniser for one level
module pfrp_sync_bit #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire clock,
    input  wire rst_n,
    input  wire din,
    output reg  dout
);
    reg stage1;

    // First stage feeds only the second
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RESET_VALUE;
            dout   <= RESET_VALUE;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // pfrp_sync_bit

//--- src/pfrp_byte_reg.v
`timescale 1ns/1ps
// Byte register with unimplemented upper bits held at zero
module pfrp_byte_reg #(
    parameter WIDTH = 8
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             load,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    // Storage covers only implemented bits
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dout <= {WIDTH{1'b0}};
        end else if (load) begin
            dout <= din;
        end
    end
endmodule // pfrp_byte_reg

//--- test/pfrp_read_port_asserts.sv
`timescale 1ns/1ps
`include "pfrp_regs.vh"
module pfrp_read_port_asserts #(
    parameter ADDR_WIDTH = 13,
    parameter WORD_WIDTH = 14,
    parameter LATENCY    = 2
) (
    input wire                        clock,
    input wire                        rst_n,
    input wire [`PFRP_ADDR_WIDTH-1:0] regAddr,
    input wire [7:0]                  regWriteData,
    input wire                        regWrite,
    input wire                        regRead,
    input wire [7:0]                  regReadData,
    input wire [ADDR_WIDTH-1:0]       flashAddr,
    input wire                        flashReadEnable,
    input wire [WORD_WIDTH-1:0]       flashReadData,
    input wire                        readBusy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Control write seen by the block
    wire ctrlWr = regWrite && regAddr == `PFRP_OFF_CONTROL;
    property p_start;
        ctrlWr && regWriteData[0] && !readBusy |=> readBusy && flashReadEnable;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_ignore0;
        ctrlWr && !regWriteData[0] && !readBusy |=> !flashReadEnable;
    endproperty
    a_ignore0: assert property (p_ignore0) else $error("zero started");
    // Fetch length fixed by the default latency of two
    property p_fetch;
        $rose(flashReadEnable) |-> flashReadEnable[*2] ##1 !flashReadEnable;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch length");
    property p_busyEn;
        flashReadEnable |-> readBusy;
    endproperty
    a_busyEn: assert property (p_busyEn) else $error("fetch idle");
    property p_addr;
        flashReadEnable && $past(flashReadEnable) |-> $stable(flashAddr);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_done;
        $rose(readBusy) |-> ##[1:6] !readBusy;
    endproperty
    a_done: assert property (p_done) else $error("read hangs");
    property p_ctrl;
        $past(regRead) && $past(regAddr) == `PFRP_OFF_CONTROL
            |-> regReadData[7:1] == 7'h40;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control bits");
    property p_hiData;
        $past(regRead) && $past(regAddr) == `PFRP_OFF_WORD_HIGH
            |-> regReadData[7:6] == 2'h0;
    endproperty
    a_hiData: assert property (p_hiData) else $error("high data bits");
endmodule // pfrp_read_port_asserts

bind pfrp_read_port pfrp_read_port_asserts #(.ADDR_WIDTH(ADDR_WIDTH),
    .WORD_WIDTH(WORD_WIDTH), .LATENCY(LATENCY)) chk_i (.clock(clock),
    .rst_n(rst_n), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .flashAddr(flashAddr), .flashReadEnable(flashReadEnable),
    .flashReadData(flashReadData), .readBusy(readBusy));

//--- test/pfrp_flash_model.sv
`timescale 1ns/1ps
module pfrp_flash_model #(
    parameter LATENCY = 2
) (
    input  wire        clock,
    input  wire        flashReadEnable,
    input  wire [12:0] flashAddr,
    output wire [13:0] flashReadData
);
    reg [13:0] mem [0:8191];
    reg [13:0] junk = 14'h0000;
    reg [3:0]  age  = 4'h0;
    reg        enD  = 1'b0;
    reg [12:0] addr = 13'h0000;
    // Fetch age; outside the sample cycle the lines toggle every clock
    always @(posedge clock) begin
        enD <= flashReadEnable;
        junk <= ~flashReadData;
        if (flashReadEnable && !enD) begin
            age <= 4'h1;
            addr <= flashAddr;
        end else if (age != 4'h0 && age != 4'hF) begin
            age <= age + 4'h1;
        end
    end
    // One whole word, standing for one cycle only
    assign flashReadData = (age == LATENCY) ? mem[addr] : junk;
endmodule // pfrp_flash_model

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "pfrp_regs.vh"
module tb_top;
    reg         clock = 1'b0;
    reg         rst_n = 1'b0;
    reg  [8:0]  regAddr = 9'h000;
    reg  [7:0]  regWriteData = 8'h00;
    reg         regWrite = 1'b0;
    reg         regRead = 1'b0;
    wire [7:0]  regReadData;
    wire [12:0] flashAddr;
    wire        flashReadEnable;
    wire [13:0] flashReadData;
    wire        readBusy;
    reg         rdD = 1'b0;
    reg  [31:0] seed = 32'hFBA4F382;
    reg  [7:0]  expq[$];
    integer     n_mismatch = 0;
    integer     n_tests = 0;
    integer     i;
    reg  [12:0] a;
    reg  [13:0] v;

    always #10 clock = ~clock;

    pfrp_read_port dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .flashAddr(flashAddr),
        .flashReadEnable(flashReadEnable), .flashReadData(flashReadData),
        .readBusy(readBusy));
    pfrp_flash_model #(.LATENCY(`PFRP_FLASH_LATENCY)) flash (.clock(clock),
        .flashReadEnable(flashReadEnable), .flashAddr(flashAddr),
        .flashReadData(flashReadData));

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0t read %h want %h", $time, got, exp);
            end
        end
    endtask

    task end_sim;
        begin
            $display("compares %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // Strobes stay up across back-to-back cycles, never set twice
    task bus(input w, input r, input [8:0] ad, input [7:0] d);
        begin
            regWrite <= w;
            regRead <= r;
            regAddr <= ad;
            regWriteData <= d;
            @(posedge clock);
        end
    endtask

    task wr(input [8:0] ad, input [7:0] d);
        bus(1'b1, 1'b0, ad, d);
    endtask

    task rd(input [8:0] ad, input [7:0] e);
        begin
            expq.push_back(e);
            bus(1'b0, 1'b1, ad, 8'h00);
        end
    endtask

    task wait_idle;
        integer j;
        begin
            j = 0;
            bus(1'b0, 1'b0, 9'h000, 8'h00);
            while (readBusy !== 1'b0 && j < 20) begin
                @(posedge clock);
                #1;
                j = j + 1;
            end
            if (j == 20) begin
                n_mismatch = n_mismatch + 1;
                end_sim;
            end
            @(posedge clock);
        end
    endtask

    // Oldest note meets the data one cycle after each read strobe
    always @(posedge clock) begin
        rdD <= regRead;
        if (rdD)
            chk(regReadData, expq.pop_front());
    end

    initial begin
        #1000000;
        n_mismatch = n_mismatch + 1;
        end_sim;
    end

    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`PFRP_OFF_CONTROL, 8'h80);
        rd(`PFRP_OFF_WORD_LOW, 8'h00);
        rd(`PFRP_OFF_WORD_HIGH, 8'h00);
        rd(9'h000, 8'h00);
        wr(`PFRP_OFF_ADDR_HIGH, 8'hFF);
        wr(`PFRP_OFF_CONTROL, 8'h7E);
        rd(`PFRP_OFF_ADDR_HIGH, 8'h1F);
        rd(`PFRP_OFF_CONTROL, 8'h80);
        $display("register test done");
        // Both ends of the space, then random words and places
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : seed[12:0];
            v = seed[27:14];
            flash.mem[a] = v;
            wr(`PFRP_OFF_ADDR_HIGH, {3'h0, a[12:8]});
            wr(`PFRP_OFF_ADDR_LOW, a[7:0]);
            wr(`PFRP_OFF_CONTROL, 8'h01);
            rd(`PFRP_OFF_CONTROL, 8'h81);
            wait_idle;
            chk({3'h0, flashAddr[12:8]}, {3'h0, a[12:8]});
            chk(flashAddr[7:0], a[7:0]);
            rd(`PFRP_OFF_CONTROL, 8'h80);
            rd(`PFRP_OFF_WORD_LOW, v[7:0]);
            rd(`PFRP_OFF_WORD_HIGH, {2'h0, v[13:8]});
            rd(`PFRP_OFF_ADDR_LOW, a[7:0]);
        end
        bus(1'b0, 1'b0, 9'h000, 8'h00);
        repeat (3) @(posedge clock);
        $display("fetch test done");
        end_sim;
    end
endmodule // tb_top
